// [seek_pkg.sv]
// constants shared by the load/seek sequencer and its helper modules
// assumes a single 100 MHz clock; the far end is the disk controller's tag logic
// Behaviour
// - load latch: gates off, cylinder zero, difference 1023
// - load latch drives forward motion until end-of-travel
// - outer guard band: drop load, enable fine gate
// - on cylinder held 1.75 ms before flip-flop sets
// - first seek on-cylinder sets unit ready, unload clears
// - unit ready sets attention when address plug present
// - no dibits 200 ms after load: retract
// - timeout gives pack unsafe, reload refused while locked
// - dibits lost 200 ms when ready: same retract
// - tag 6 loads bus out into low cylinder bits
// - tag 6 clears head, presets difference to 1023
// - tag 7 byte: 512, 256, unused, head bits
// - tag 7 loads upper cylinder and difference bits
// - tag 7 loads five head address bits
// - tag 8 with control bit 2 set writes complement into difference low byte
// - seek start without fault sets seek flip-flops
// - each cylinder pulse outside load and fine, with no preset or tag load in the same cycle, increments difference counter, holding at 1023
// - first seek end: complete, on line, not busy
package seek_pkg;
  // ==========================================================
  // timing
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int DIBIT_TIMEOUT_MS = 200;
  localparam int DIBIT_TIMEOUT_CYC = DIBIT_TIMEOUT_MS * CLK_FREQ_KHZ;
  localparam int ON_CYL_DELAY_US = 1750;
  localparam int ON_CYL_DELAY_CYC = ON_CYL_DELAY_US * CLK_FREQ_KHZ / 1000;
  // ==========================================================
  // counter and register values
  localparam logic [9:0] DIFF_MAX = 10'h3ff;
  localparam logic [9:0] CYL_ZERO = 10'h000;
  localparam logic [4:0] HEAD_ZERO = 5'h00;
  // ==========================================================
  // tags and bus out bit positions
  localparam logic [3:0] TAG_CYL = 4'h6;
  localparam logic [3:0] TAG_HEAD = 4'h7;
  localparam logic [3:0] TAG_DIFF = 4'h8;
  localparam logic [3:0] TAG_CTRL = 4'h9;
  localparam int BOB_CYL512 = 0;
  localparam int BOB_CYL256 = 1;
  localparam int BOB_SEEK_START = 3;
  localparam int BOB_CTRL_RESET = 6;
  // ==========================================================
  // wishbone register map
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CYL = 8'h04;
  localparam logic [7:0] REG_POS = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;
  localparam int CTRL_CLR_LOCK = 0;
  localparam int CTRL_CLR_ATTN = 1;
  localparam int CTRL_RESET = 2;
  localparam int POS_DIFF_LSB = 0;
  localparam int POS_HEAD_LSB = 16;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_READY = 8;
  localparam int STAT_ATTN = 9;
  localparam int STAT_FAULT = 10;
  localparam int STAT_LOCK = 11;
  localparam int STAT_SEEK = 12;
  localparam int STAT_COMPLETE = 13;
  localparam int STAT_ONLINE = 14;
  localparam int STAT_BUSY = 15;
  // ==========================================================
  // sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LOAD = 5'b00010,
    ST_FINE = 5'b00100,
    ST_READY = 5'b01000,
    ST_RTZ = 5'b10000
  } seq_state_t;
endpackage : seek_pkg

// [delay_timer.sv]
// run-gated delay: done rises CYCLES edges after run rose
// assumes run_i is a level; dropping it restarts the count
`timescale 1ns/1ns
module delay_timer #(
  parameter int CYCLES = 4,
  parameter int W = $clog2(CYCLES + 1)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic done_o
);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  logic [W-1:0] cnt_ff;

  // count stops at the last value so done stays a level
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_ff <= '0;
      done_o <= 1'b0;
    end else begin
      if (cnt_ff != LAST) cnt_ff <= cnt_ff + W'(1);
      done_o <= (cnt_ff == LAST);
    end
  end
endmodule : delay_timer

// [diff_counter.sv]
// ten-bit cylinder difference counter, 1023 means target reached
// assumes load strobes are single-cycle and mutually exclusive
`timescale 1ns/1ns
module diff_counter import seek_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic preset_i,
  input wire logic load_hi_i,
  input wire logic [1:0] hi_i,
  input wire logic load_lo_i,
  input wire logic [7:0] lo_i,
  input wire logic incr_i,
  output logic [9:0] diff_o,
  output logic at_target_o
);
  // preset beats loads, loads beat counting
  always_ff @(posedge clk_i) begin
    if (rst_i || preset_i) begin
      diff_o <= DIFF_MAX;
    end else if (load_hi_i) begin
      diff_o[9:8] <= hi_i;
    end else if (load_lo_i) begin
      diff_o[7:0] <= lo_i;
    end else if (incr_i && diff_o != DIFF_MAX) begin
      diff_o <= diff_o + 10'h001;
    end
  end

  assign at_target_o = (diff_o == DIFF_MAX);
endmodule : diff_counter

// [disk_seek_load_sequencer.sv]
// first-seek load sequencer and direct-seek tag receiver of a disk drive
// assumes drive sense inputs and controller tags are synchronous to clk_i;
// software reaches status and control over a classic wishbone slave
`timescale 1ns/1ns
module disk_seek_load_sequencer import seek_pkg::*; #(
  parameter int DIBIT_CYC = DIBIT_TIMEOUT_CYC,
  parameter int SETTLE_CYC = ON_CYL_DELAY_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic first_seek_start_i,
  input wire logic odd_dibits_i,
  input wire logic dibits_present_i,
  input wire logic on_cyl_detect_i,
  input wire logic cyl_pulse_i,
  input wire logic heads_unloaded_i,
  input wire logic addr_plug_i,
  input wire logic tag_strobe_i,
  input wire logic [3:0] tag_code_i,
  input wire logic [7:0] bus_out_i,
  input wire logic ctl_bit2_i,
  output logic load_gate_o,
  output logic fwd_motion_o,
  output logic coarse_gate_o,
  output logic fine_gate_o,
  output logic retract_o,
  output logic unit_ready_o,
  output logic attention_o,
  output logic device_fault_o,
  output logic select_lock_o,
  output logic seek_o,
  output logic seek_fwd_o,
  output logic fwd_o,
  output logic seek_complete_o,
  output logic on_line_o,
  output logic busy_o,
  output logic [9:0] cyl_addr_o,
  output logic [4:0] head_addr_o,
  output logic [9:0] diff_o
);
  // ==========================================================
  // decode helpers
  function automatic logic tag_hit(input logic stb, input logic [3:0] code,
                                   input logic [3:0] want);
    tag_hit = stb && (code == want);
  endfunction : tag_hit

  // head weights run 16..1 on bits 3..7, so the field is reversed
  function automatic logic [4:0] head_field(input logic [7:0] b);
    head_field = {b[3], b[4], b[5], b[6], b[7]};
  endfunction : head_field

  seq_state_t state_ff, nxt_state;
  logic rev_eot_ff, dibits_seen_ff, on_cyl_ff;
  logic dibit_timeout, settle_done, at_target;

  // ==========================================================
  // wishbone slave
  wire wb_req = cyc_i && stb_i && !ack_o;
  wire wr_ctrl = cyc_i && stb_i && we_i && ack_o && sel_i[0] && (adr_i == REG_CTRL);
  wire clr_lock = wr_ctrl && dat_i[CTRL_CLR_LOCK];
  wire clr_attn = wr_ctrl && dat_i[CTRL_CLR_ATTN];
  logic [31:0] status_w, pos_w, rd_w;

  // status word gathered from the live flip-flops
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[STAT_STATE_LSB +: 5] = state_ff;
    status_w[STAT_READY] = unit_ready_o;
    status_w[STAT_ATTN] = attention_o;
    status_w[STAT_FAULT] = device_fault_o;
    status_w[STAT_LOCK] = select_lock_o;
    status_w[STAT_SEEK] = seek_o;
    status_w[STAT_COMPLETE] = seek_complete_o;
    status_w[STAT_ONLINE] = on_line_o;
    status_w[STAT_BUSY] = busy_o;
    pos_w = 32'h0000_0000;
    pos_w[POS_DIFF_LSB +: 10] = diff_o;
    pos_w[POS_HEAD_LSB +: 5] = head_addr_o;
  end

  // unmapped addresses and the control word read as zero
  assign rd_w = (adr_i == REG_STATUS) ? status_w :
                (adr_i == REG_CYL) ? {22'h000000, cyl_addr_o} :
                (adr_i == REG_POS) ? pos_w : 32'h0000_0000;

  // ack one cycle after the request; writes land on the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= wb_req;
      dat_o <= (wb_req && !we_i) ? rd_w : 32'h0000_0000;
    end
  end

  // ==========================================================
  // tag decode
  wire tag_cyl = tag_hit(tag_strobe_i, tag_code_i, TAG_CYL);
  wire tag_head = tag_hit(tag_strobe_i, tag_code_i, TAG_HEAD);
  wire tag_diff = tag_hit(tag_strobe_i, tag_code_i, TAG_DIFF) && ctl_bit2_i;
  wire tag_ctrl = tag_hit(tag_strobe_i, tag_code_i, TAG_CTRL);
  wire ctl_reset = (tag_ctrl && bus_out_i[BOB_CTRL_RESET]) ||
                   (wr_ctrl && dat_i[CTRL_RESET]);

  // ==========================================================
  // sequence events
  wire in_load = (state_ff == ST_LOAD);
  wire in_fine = (state_ff == ST_FINE);
  wire in_ready = (state_ff == ST_READY);
  wire load_entry = (state_ff == ST_IDLE) && first_seek_start_i && !select_lock_o;
  wire ready_set = in_fine && !dibit_timeout && settle_done;
  wire fault_set = dibit_timeout && (in_load || in_fine || in_ready);
  wire abort = load_entry || fault_set || ctl_reset;
  wire seek_start = tag_ctrl && bus_out_i[BOB_SEEK_START] && !device_fault_o && !abort;
  wire nxt_rev_eot = in_load && (odd_dibits_i || rev_eot_ff);
  wire nxt_seek = !abort && (seek_start || (seek_o && !at_target));
  // first-seek cylinder pulses must not move the counter
  wire cyl_incr = cyl_pulse_i && !in_load && !in_fine;

  // dibit watchdog: until first seen while loading, or whenever lost later
  wire dibit_run = (in_load && !dibits_seen_ff) ||
                   ((in_fine || in_ready) && !dibits_present_i);
  wire settle_run = in_fine && on_cyl_detect_i;

  delay_timer #(
    .CYCLES(DIBIT_CYC)
  ) u_dibit_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(dibit_run),
    .done_o(dibit_timeout)
  );

  delay_timer #(
    .CYCLES(SETTLE_CYC)
  ) u_settle_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(settle_run),
    .done_o(settle_done)
  );

  diff_counter u_diff (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .preset_i(load_entry || tag_cyl),
    .load_hi_i(tag_head),
    .hi_i({bus_out_i[BOB_CYL512], bus_out_i[BOB_CYL256]}),
    .load_lo_i(tag_diff),
    .lo_i(~bus_out_i),
    .incr_i(cyl_incr),
    .diff_o(diff_o),
    .at_target_o(at_target)
  );

  // ==========================================================
  // first seek state machine
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: if (load_entry) nxt_state = ST_LOAD;
      ST_LOAD: begin
        if (dibit_timeout) nxt_state = ST_RTZ;
        else if (rev_eot_ff) nxt_state = ST_FINE;
      end
      ST_FINE: begin
        if (dibit_timeout) nxt_state = ST_RTZ;
        else if (settle_done) nxt_state = ST_READY;
      end
      ST_READY: begin
        if (heads_unloaded_i) nxt_state = ST_IDLE;
        else if (dibit_timeout) nxt_state = ST_RTZ;
      end
      ST_RTZ: if (heads_unloaded_i) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // state and motion gates, all taken from the next state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      rev_eot_ff <= 1'b0;
      load_gate_o <= 1'b0;
      fwd_motion_o <= 1'b0;
      fine_gate_o <= 1'b0;
      retract_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      rev_eot_ff <= nxt_rev_eot;
      load_gate_o <= (nxt_state == ST_LOAD);
      fwd_motion_o <= (nxt_state == ST_LOAD) && !nxt_rev_eot;
      fine_gate_o <= (nxt_state == ST_FINE) || (nxt_state == ST_READY);
      retract_o <= (nxt_state == ST_RTZ);
    end
  end

  // ==========================================================
  // ready, attention and pack-unsafe flags; a set beats a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dibits_seen_ff <= 1'b0;
      on_cyl_ff <= 1'b0;
      unit_ready_o <= 1'b0;
      attention_o <= 1'b0;
      device_fault_o <= 1'b0;
      select_lock_o <= 1'b0;
    end else begin
      dibits_seen_ff <= in_load && (dibits_present_i || dibits_seen_ff);
      on_cyl_ff <= ready_set || (on_cyl_ff && in_ready);
      unit_ready_o <= ready_set || (unit_ready_o && !heads_unloaded_i);
      attention_o <= (ready_set && addr_plug_i) ||
                     (attention_o && !clr_attn && !ctl_reset);
      device_fault_o <= fault_set || (device_fault_o && !ctl_reset);
      select_lock_o <= fault_set || (select_lock_o && !clr_lock);
    end
  end

  // ==========================================================
  // bus-in status and direct seek flip-flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seek_complete_o <= 1'b0;
      on_line_o <= 1'b0;
      busy_o <= 1'b0;
      seek_o <= 1'b0;
      coarse_gate_o <= 1'b0;
      seek_fwd_o <= 1'b0;
      fwd_o <= 1'b0;
    end else begin
      seek_complete_o <= ready_set || (seek_o && at_target && !abort) ||
                         (seek_complete_o && !load_entry && !fault_set && !seek_start);
      on_line_o <= ready_set || (on_line_o && !heads_unloaded_i && !fault_set);
      busy_o <= load_entry || (busy_o && !ready_set && nxt_state != ST_IDLE);
      seek_o <= nxt_seek;
      coarse_gate_o <= nxt_seek;
      seek_fwd_o <= seek_start || (seek_fwd_o && !abort);
      fwd_o <= seek_start || (fwd_o && !abort);
    end
  end

  // ==========================================================
  // cylinder and head address registers
  always_ff @(posedge clk_i) begin
    if (rst_i || load_entry) begin
      cyl_addr_o <= CYL_ZERO;
    end else if (tag_cyl) begin
      cyl_addr_o[7:0] <= bus_out_i;
    end else if (tag_head) begin
      cyl_addr_o[9:8] <= {bus_out_i[BOB_CYL512], bus_out_i[BOB_CYL256]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || tag_cyl) begin
      head_addr_o <= HEAD_ZERO;
    end else if (tag_head) begin
      head_addr_o <= head_field(bus_out_i);
    end
  end

  // ==========================================================
  // checks; settle_cnt_ff only feeds the settle check
  logic [31:0] settle_cnt_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i || !settle_run) settle_cnt_ff <= 32'h0000_0000;
    else settle_cnt_ff <= settle_cnt_ff + 32'h0000_0001;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence load_begins;
    $rose(load_gate_o);
  endsequence

  sequence eot_seen;
    load_gate_o && rev_eot_ff && !dibit_timeout;
  endsequence

  a_load_entry_clear: assert property (load_begins |-> diff_o == DIFF_MAX &&
    cyl_addr_o == CYL_ZERO && !fine_gate_o && !coarse_gate_o)
    else $error("load entry did not clear gates and registers");
  a_fwd_while_load: assert property (load_gate_o && !rev_eot_ff |-> fwd_motion_o)
    else $error("no forward motion while loading");
  a_eot_to_fine: assert property (eot_seen |=> fine_gate_o && !load_gate_o && !fwd_motion_o)
    else $error("guard band did not hand over to fine servo");
  a_settle_delay: assert property ($rose(on_cyl_ff) |-> $past(settle_cnt_ff) >= SETTLE_CYC)
    else $error("on cylinder set before settle delay");
  a_ready_on_cyl: assert property ($rose(on_cyl_ff) |-> unit_ready_o && seek_complete_o && on_line_o && !busy_o)
    else $error("first seek end status wrong");
  a_ready_holds: assert property (unit_ready_o && !heads_unloaded_i |=> unit_ready_o)
    else $error("unit ready dropped without unload");
  a_attn_plug: assert property ($rose(attention_o) |-> $rose(unit_ready_o) && $past(addr_plug_i))
    else $error("attention without ready and plug");
  a_timeout_unsafe: assert property (fault_set |=> retract_o && device_fault_o && select_lock_o)
    else $error("dibit timeout did not retract");
  a_reload_refused: assert property (select_lock_o && !load_gate_o |=> !load_gate_o)
    else $error("reload while select lock set");
  a_tag6_load: assert property (tag_cyl && !load_entry |=> cyl_addr_o[7:0] == $past(bus_out_i) &&
    head_addr_o == HEAD_ZERO && diff_o == DIFF_MAX)
    else $error("tag 6 load wrong");
  a_tag7_load: assert property (tag_head && !load_entry |=> head_addr_o == head_field($past(bus_out_i)) &&
    cyl_addr_o[9] == $past(bus_out_i[0]) && diff_o[8] == $past(bus_out_i[1]))
    else $error("tag 7 load wrong");
  a_tag8_comp: assert property (tag_diff && !load_entry |=> diff_o[7:0] == ~$past(bus_out_i))
    else $error("difference complement wrong");
  a_seek_start: assert property (seek_start |=> seek_o && seek_fwd_o && fwd_o ##1 seek_o || at_target)
    else $error("seek did not start");
  a_seek_fault: assert property (device_fault_o && !seek_o |=> !seek_o)
    else $error("seek started under fault");
  a_diff_count: assert property (cyl_incr && !tag_strobe_i && !load_entry |=>
    diff_o == (($past(diff_o) == DIFF_MAX) ? DIFF_MAX : $past(diff_o) + 10'h001))
    else $error("difference count step wrong");
endmodule : disk_seek_load_sequencer

// [tag_ctrl_model.sv]
// disk controller tag side: issues one tagged bus-out transfer per send request
// assumes send_i is a one-cycle request from the bench on the shared clock
`timescale 1ns/1ns
module tag_ctrl_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic send_i,
  input wire logic [3:0] code_i,
  input wire logic [7:0] byte_i,
  input wire logic c2_i,
  output logic tag_strobe_o,
  output logic [3:0] tag_code_o,
  output logic [7:0] bus_out_o,
  output logic ctl_bit2_o
);
  // ==========================================================
  // tag driver
  // released lines show the inverse of the last value so stale data never passes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tag_strobe_o <= 1'b0;
      tag_code_o <= 4'h0;
      bus_out_o <= 8'h00;
      ctl_bit2_o <= 1'b0;
    end else if (send_i) begin
      tag_strobe_o <= 1'b1;
      tag_code_o <= code_i;
      bus_out_o <= byte_i;
      ctl_bit2_o <= c2_i;
    end else begin
      tag_strobe_o <= 1'b0;
      tag_code_o <= ~tag_code_o;
      bus_out_o <= ~bus_out_o;
      ctl_bit2_o <= ~ctl_bit2_o;
    end
  end
endmodule : tag_ctrl_model

// [tb.sv]
// self-checking bench for the load/seek sequencer against an integer model
// assumes shortened watchdog and settle counts; wishbone master runs from tasks
`timescale 1ns/1ns
module tb;
  import seek_pkg::*;
  localparam int DIB = 40;
  localparam int SET = 20;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [7:0] adr_i, bus_out_i, sbyte;
  logic [3:0] sel_i, tag_code_i, scode;
  logic [31:0] dat_i, dat_o, rd;
  logic first_seek_start_i, odd_dibits_i, dibits_present_i, on_cyl_detect_i, cyl_pulse_i;
  logic heads_unloaded_i, addr_plug_i, tag_strobe_i, ctl_bit2_i, send, sc2;
  logic load_gate_o, fwd_motion_o, coarse_gate_o, fine_gate_o, retract_o, unit_ready_o, attention_o;
  logic device_fault_o, select_lock_o, seek_o, seek_fwd_o, fwd_o, seek_complete_o, on_line_o, busy_o;
  logic [9:0] cyl_addr_o, diff_o;
  logic [4:0] head_addr_o;
  int miscompares, compares, cyl_m, head_m, diff_m;
  // ==========================================================
  // design and controller model
  disk_seek_load_sequencer #(.DIBIT_CYC(DIB), .SETTLE_CYC(SET)) u_disk_seek_load_sequencer (.*);
  tag_ctrl_model u_tag_ctrl_model (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .code_i(scode),
    .byte_i(sbyte), .c2_i(sc2), .tag_strobe_o(tag_strobe_i), .tag_code_o(tag_code_i),
    .bus_out_o(bus_out_i), .ctl_bit2_o(ctl_bit2_i));
  // ==========================================================
  // compare, wait and closing tasks
  task cmp_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val
  task cmp_bit(input logic got, input logic exp);
    cmp_val({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit
  task conclude;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // bounded wait; a run-out counts against the design and ends the run
  task automatic wait_hi(ref logic s, input int lim);
    int i;
    i = 0;
    while (s !== 1'b1 && i < lim) begin
      tick(1);
      i++;
    end
    if (s !== 1'b1) begin
      miscompares++;
      conclude();
    end
  endtask : wait_hi
  // ==========================================================
  // wishbone classic master: hold until ack is sampled, then release
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    sel_i <= 4'hf;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && i < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (i >= 20) begin
      miscompares++;
      conclude();
    end
  endtask : wb
  // ==========================================================
  // one tag through the controller model, then model update and compare
  task tag(input logic [3:0] c, input logic [7:0] b, input logic k);
    @(posedge clk_i);
    send <= 1'b1;
    scode <= c;
    sbyte <= b;
    sc2 <= k;
    @(posedge clk_i);
    send <= 1'b0;
    tick(1);
    if (c == TAG_CYL) begin
      cyl_m = (cyl_m & 'h300) | b;
      head_m = 0;
      diff_m = 1023;
    end else if (c == TAG_HEAD) begin
      cyl_m = (cyl_m & 'hff) | (b[0] * 512) | (b[1] * 256);
      diff_m = (diff_m & 'hff) | (b[0] * 512) | (b[1] * 256);
      head_m = b[3] * 16 + b[4] * 8 + b[5] * 4 + b[6] * 2 + b[7];
    end else if (c == TAG_DIFF && k) begin
      diff_m = (diff_m & 'h300) | (255 - b);
    end
    cmp_val(cyl_addr_o, cyl_m);
    cmp_val(head_addr_o, head_m);
    cmp_val(diff_o, diff_m);
  endtask : tag
  // ==========================================================
  // clock and main sequence
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #1000000;
    miscompares++;
    conclude();
  end
  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {1'b1, 47'h0};
    {first_seek_start_i, odd_dibits_i, dibits_present_i, on_cyl_detect_i, cyl_pulse_i} = 5'h0;
    {heads_unloaded_i, addr_plug_i, send, scode, sbyte, sc2} = {2'b01, 14'h0};
    {miscompares, compares, cyl_m, head_m, diff_m} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd1023};
    void'($urandom(32'hfde02728));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    cmp_val(diff_o, 10'h3ff);
    cmp_val({load_gate_o, seek_o, unit_ready_o, retract_o, cyl_addr_o}, 0);
    wb(1'b0, REG_STATUS, 0);
    cmp_val(rd, 32'h1);
    wb(1'b0, 8'h10, 0);
    cmp_val(rd, 32'h0);
    // address, difference tags in random order and content
    repeat (12) tag(4'(6 + $urandom % 3), 8'($urandom), 1'($urandom));
    wb(1'b0, REG_CYL, 0);
    cmp_val(rd, cyl_m);
    tag(TAG_CTRL, 8'h08, 1'b0);
    cmp_val({seek_o, coarse_gate_o, seek_fwd_o, fwd_o}, 4'hf);
    while (diff_m < 1023) begin
      @(posedge clk_i);
      cyl_pulse_i <= 1'b1;
      @(posedge clk_i);
      cyl_pulse_i <= 1'b0;
      #1;
      diff_m++;
      cmp_val(diff_o, diff_m);
    end
    tick(2);
    cmp_val({seek_o, seek_complete_o}, 2'b01);
    @(posedge clk_i);
    cyl_pulse_i <= 1'b1;
    @(posedge clk_i);
    cyl_pulse_i <= 1'b0;
    tick(1);
    cmp_val(diff_o, 10'h3ff);
    // first seek: load, guard band, settle, ready
    @(posedge clk_i);
    first_seek_start_i <= 1'b1;
    dibits_present_i <= 1'b1;
    addr_plug_i <= 1'($urandom);
    @(posedge clk_i);
    first_seek_start_i <= 1'b0;
    #1;
    // load entry clears the cylinder register, so the model follows
    cyl_m = 0;
    cmp_val({load_gate_o, fwd_motion_o, busy_o, fine_gate_o, coarse_gate_o}, 5'h1c);
    cmp_val({cyl_addr_o, diff_o}, 20'h003ff);
    tick(4);
    cmp_bit(fwd_motion_o, 1'b1);
    @(posedge clk_i);
    odd_dibits_i <= 1'b1;
    tick(3);
    cmp_val({fwd_motion_o, load_gate_o, fine_gate_o}, 3'b001);
    @(posedge clk_i);
    odd_dibits_i <= 1'b0;
    on_cyl_detect_i <= 1'b1;
    tick(SET - 2);
    cmp_bit(unit_ready_o, 1'b0);
    wait_hi(unit_ready_o, 8);
    tick(1);
    wb(1'b0, REG_STATUS, 0);
    cmp_val(rd, 32'h6108 | (32'(addr_plug_i) << 9));
    // dibits lost while ready: retract and lock
    @(posedge clk_i);
    dibits_present_i <= 1'b0;
    tick(DIB - 4);
    cmp_bit(retract_o, 1'b0);
    wait_hi(retract_o, 10);
    tick(1);
    cmp_val({device_fault_o, select_lock_o, unit_ready_o, fine_gate_o}, 4'he);
    @(posedge clk_i);
    heads_unloaded_i <= 1'b1;
    on_cyl_detect_i <= 1'b0;
    tick(3);
    cmp_bit(unit_ready_o, 1'b0);
    @(posedge clk_i);
    first_seek_start_i <= 1'b1;
    @(posedge clk_i);
    first_seek_start_i <= 1'b0;
    tick(2);
    cmp_bit(load_gate_o, 1'b0);
    tag(TAG_CTRL, 8'h08, 1'b0);
    cmp_bit(seek_o, 1'b0);
    wb(1'b1, REG_CTRL, 32'h3);
    tick(1);
    cmp_val({attention_o, select_lock_o}, 2'b00);
    tag(TAG_CTRL, 8'h40, 1'b0);
    cmp_val({device_fault_o, select_lock_o}, 2'b00);
    // load with no dibits at all
    @(posedge clk_i);
    heads_unloaded_i <= 1'b0;
    first_seek_start_i <= 1'b1;
    @(posedge clk_i);
    first_seek_start_i <= 1'b0;
    tick(DIB - 4);
    cmp_val({load_gate_o, retract_o}, 2'b10);
    wait_hi(retract_o, 10);
    tick(1);
    cmp_val({device_fault_o, select_lock_o, load_gate_o}, 3'b110);
    conclude();
  end
endmodule : tb
